// [logic/uis_defines.svh]
`ifndef UIS_DEFINES_SVH
`define UIS_DEFINES_SVH

`define UIS_OFF_IER    12'h004
`define UIS_OFF_FSR    12'h018
`define UIS_OFF_ISR    12'h01C
`define UIS_OFF_TOR    12'h020
`define UIS_OFF_MSR    12'h02C
`define UIS_OFF_MODE   12'h030
`define UIS_OFF_IRQS   12'h040
`define UIS_OFF_IRQM   12'h044

`define UIS_IER_CTS    3
`define UIS_IER_RLS    2
`define UIS_IER_TOUT   4
`define UIS_IER_BUF    5
`define UIS_IER_LIN    8

`define UIS_FSR_BRK    6
`define UIS_FSR_FRM    5
`define UIS_FSR_PAR    4
`define UIS_FSR_ADDR   3
`define UIS_MSR_DCTS   0
`define UIS_MODE_485   0

`define UIS_IER_RST    9'h000
`define UIS_TOR_RST    8'h40
`define UIS_CNT_MAX    8'hFF
`define UIS_NEV        6
`define UIS_NO_CTS_CH  2

`endif

// [logic/uis_pkg.sv]
package uis_pkg;

  typedef struct packed {
    logic hdr_det;
    logic brk_det;
    logic bit_err;
    logic id_perr;
    logic hdr_err;
  } uis_lin_s;

  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
    logic addr;
  } uis_rxerr_s;

  typedef logic [7:0] uis_cnt_t;

endpackage

// [logic/uis_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "uis_defines.svh"

module uis_top #(
  parameter int CHANNEL = 0
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               rx_nonempty,
  input  wire logic               rx_activity,
  input  wire logic               rx_active,
  input  wire logic               rbr_read,
  input  wire logic               cts_change,
  input  wire uis_pkg::uis_rxerr_s rx_err_ev,
  input  wire uis_pkg::uis_lin_s  lin_status,
  input  wire logic               buf_err_flag,
  input  wire logic               timeout_flag,
  output logic                    irq
);
  import uis_pkg::*;

  logic [8:0]          ien_r;
  uis_cnt_t            tor_r;
  uis_cnt_t            cnt_r;
  uis_rxerr_s          fsr_r;
  logic                dcts_r;
  logic                rs485_r;
  logic                dma_tout_r;
  logic                dma_cts_r;
  logic                dma_rls_r;
  logic                lin_flag_r;
  logic                lin_int_r;
  logic                buf_int_r;
  logic                tout_int_r;
  logic [`UIS_NEV-1:0] sts_r;
  logic [`UIS_NEV-1:0] msk_r;
  logic [`UIS_NEV-1:0] ev;
  logic [31:0]         prdata_r;
  logic                pready_r;
  logic                pslverr_r;
  logic                irq_r;
  logic [31:0]         rdata;
  logic [31:0]         isr;
  logic                hit;
  logic                wr;
  logic                tout_hit;
  logic                rbr_clr;
  logic                rls_any;

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

  assign wr = psel & penable & pready_r & pwrite & ~pslverr_r;

  // Interrupt status view; reserved positions are constant zero.
  assign isr = {11'h000, dma_tout_r, dma_cts_r, dma_rls_r, 2'h0,
                lin_int_r, 1'b0, buf_int_r, tout_int_r, 4'h0,
                lin_flag_r, 1'b0, buf_err_flag, timeout_flag, 4'h0};

  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    unique case (paddr)
      `UIS_OFF_IER:  rdata = {23'h000000, ien_r};
      `UIS_OFF_FSR:  rdata = {25'h0000000, fsr_r, 3'h0};
      `UIS_OFF_ISR:  rdata = isr;
      `UIS_OFF_TOR:  rdata = {24'h000000, tor_r};
      `UIS_OFF_MSR:  rdata = {31'h00000000, dcts_r};
      `UIS_OFF_MODE: rdata = {31'h00000000, rs485_r};
      `UIS_OFF_IRQS: rdata = {26'h0000000, sts_r};
      `UIS_OFF_IRQM: rdata = {26'h0000000, msk_r};
      default:       hit = 1'b0;
    endcase
  end

  // Zero-wait slave: the access phase completes on its first edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~hit;
      if (psel && !penable) begin
        prdata_r <= rdata;
      end
    end
  end

  // Software-owned control registers; writes to the status view are dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_r   <= `UIS_IER_RST;
      tor_r   <= `UIS_TOR_RST;
      rs485_r <= 1'b0;
      msk_r   <= '0;
    end else if (wr) begin
      if (paddr == `UIS_OFF_IER) begin
        ien_r <= pwdata[8:0];
      end
      if (paddr == `UIS_OFF_TOR) begin
        tor_r <= pwdata[7:0];
      end
      if (paddr == `UIS_OFF_MODE) begin
        rs485_r <= pwdata[`UIS_MODE_485];
      end
      if (paddr == `UIS_OFF_IRQM) begin
        msk_r <= pwdata[`UIS_NEV-1:0];
      end
    end
  end

  // Idle counter restarts on any FIFO activity or when the FIFO empties.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!rx_nonempty || rx_activity) begin
      cnt_r <= '0;
    end else if (cnt_r != `UIS_CNT_MAX) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign tout_hit = rx_nonempty & ~rx_activity & (cnt_r == tor_r);
  assign rbr_clr  = rbr_read & rx_active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_tout_r <= 1'b0;
    end else if (tout_hit) begin
      dma_tout_r <= 1'b1;
    end else if (rbr_clr) begin
      dma_tout_r <= 1'b0;
    end
  end

  // Delta-CTS: a new change wins over a simultaneous write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcts_r <= 1'b0;
    end else if (cts_change) begin
      dcts_r <= 1'b1;
    end else if (wr && paddr == `UIS_OFF_MSR && pwdata[`UIS_MSR_DCTS]) begin
      dcts_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_cts_r <= 1'b0;
    end else begin
      dma_cts_r <= (CHANNEL != `UIS_NO_CTS_CH) & dcts_r;
    end
  end

  // Receive error bits, each set by its event (the address bit only in RS-485 mode) and cleared by writing one.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_fsr
      logic set;
      logic clr;
      assign set = (gi == 0) ? rx_err_ev[gi] & rs485_r : rx_err_ev[gi];
      assign clr = wr & (paddr == `UIS_OFF_FSR) & pwdata[`UIS_FSR_ADDR+gi];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fsr_r[gi] <= 1'b0;
        end else if (set) begin
          fsr_r[gi] <= 1'b1;
        end else if (clr) begin
          fsr_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign rls_any = fsr_r.brk | fsr_r.frm | fsr_r.par
                 | (rs485_r & fsr_r.addr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_rls_r  <= 1'b0;
      lin_flag_r <= 1'b0;
    end else begin
      dma_rls_r  <= rls_any;
      lin_flag_r <= |lin_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_int_r  <= 1'b0;
      buf_int_r  <= 1'b0;
      tout_int_r <= 1'b0;
    end else begin
      lin_int_r  <= ien_r[`UIS_IER_LIN] & lin_flag_r;
      buf_int_r  <= ien_r[`UIS_IER_BUF] & buf_err_flag;
      tout_int_r <= ien_r[`UIS_IER_TOUT] & timeout_flag;
    end
  end

  assign ev = {dma_tout_r & ien_r[`UIS_IER_TOUT],
               dma_cts_r & ien_r[`UIS_IER_CTS],
               dma_rls_r & ien_r[`UIS_IER_RLS],
               lin_int_r, buf_int_r, tout_int_r};

  // Sticky status: an event in the clearing cycle keeps its bit set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_r <= '0;
    end else if (wr && paddr == `UIS_OFF_IRQS) begin
      sts_r <= (sts_r & ~pwdata[`UIS_NEV-1:0]) | ev;
    end else begin
      sts_r <= sts_r | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(sts_r & msk_r);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_msr_w1c;
    wr && paddr == `UIS_OFF_MSR && pwdata[`UIS_MSR_DCTS] && !cts_change;
  endsequence

  sequence s_rbr_clear;
    dma_tout_r && rbr_clr && !tout_hit;
  endsequence

  a_tout_flag_set: assert property (
    tout_hit |=> dma_tout_r)
    else $error("time-out flag not set on compare match");

  a_tout_flag_clr: assert property (
    s_rbr_clear |=> !dma_tout_r)
    else $error("time-out flag not cleared by buffer read");

  a_tout_flag_hold: assert property (
    dma_tout_r && !rbr_clr |=> dma_tout_r)
    else $error("time-out flag dropped without buffer read");

  a_cts_flag_set: assert property (
    cts_change && CHANNEL != `UIS_NO_CTS_CH |=> ##1 dma_cts_r)
    else $error("modem flag not set after CTS change");

  a_cts_flag_clr: assert property (
    s_msr_w1c ##1 !cts_change |=> !dma_cts_r)
    else $error("modem flag not cleared after delta clear");

  a_cts_absent_ch: assert property (
    CHANNEL == `UIS_NO_CTS_CH |-> !dma_cts_r)
    else $error("modem flag present on channel without it");

  a_rls_err_set: assert property (
    (rx_err_ev.brk || rx_err_ev.frm || rx_err_ev.par) |=> ##1 dma_rls_r)
    else $error("line status flag not set after error");

  a_rls_addr_set: assert property (
    rx_err_ev.addr && rs485_r |=> ##1 dma_rls_r)
    else $error("line status flag not set on address char");

  a_rls_plain_drop: assert property (
    !rs485_r && !fsr_r.brk && !fsr_r.frm && !fsr_r.par |=> !dma_rls_r)
    else $error("line status flag stuck with errors clear");

  a_rls_485_hold: assert property (
    rs485_r && fsr_r.addr |=> dma_rls_r)
    else $error("line status flag dropped with address bit set");

  a_lin_int_and: assert property (
    (|lin_status) ##1 ien_r[`UIS_IER_LIN] |=> lin_int_r)
    else $error("LIN indicator not set from flag and enable");

  a_buf_int_and: assert property (
    ##1 buf_int_r == ($past(ien_r[`UIS_IER_BUF]) && $past(buf_err_flag)))
    else $error("buffer error indicator mismatch");

  a_tout_int_and: assert property (
    ##1 tout_int_r == ($past(ien_r[`UIS_IER_TOUT]) && $past(timeout_flag)))
    else $error("time-out indicator mismatch");

  a_tout_irq_path: assert property (
    dma_tout_r && ien_r[`UIS_IER_TOUT] ##1 msk_r[`UIS_NEV-1]
      |=> irq_r)
    else $error("time-out interrupt not raised when enabled");

  a_isr_reserved: assert property (
    psel && !penable && paddr == `UIS_OFF_ISR
      |=> prdata_r[17:16] == 2'h0 && !prdata_r[14] && pready_r)
    else $error("reserved interrupt status bits not zero");

endmodule

`default_nettype wire

// [testbench/uis_remote_model.sv]
`timescale 1ns/10ps
`default_nettype none

module uis_remote_model (
  input  wire logic                pclk,
  output logic                     cts_change,
  output uis_pkg::uis_rxerr_s      rx_err_ev,
  output uis_pkg::uis_lin_s        lin_status
);
  import uis_pkg::*;

  initial begin
    cts_change = 1'b0;
    rx_err_ev  = '0;
    lin_status = '0;
  end

  // A CTS edge on the line shows as a one-cycle change pulse.
  task automatic pulse_cts();
    cts_change <= 1'b1;
    @(posedge pclk);
    cts_change <= 1'b0;
  endtask

  // A received character with errors gives one-cycle event pulses.
  task automatic pulse_err(input uis_rxerr_s e);
    rx_err_ev <= e;
    @(posedge pclk);
    rx_err_ev <= '0;
  endtask

  // LIN conditions are levels held until the far side drops them.
  task automatic set_lin(input uis_lin_s l);
    lin_status <= l;
  endtask
endmodule

`default_nettype wire

// [testbench/uart_interrupt_status_logic_test.sv]
`timescale 1ns/10ps
`default_nettype none
`include "uis_defines.svh"

module uart_interrupt_status_logic_test;
  import uis_pkg::*;

  localparam logic [31:0] B_TOUT = 32'h0010_0000;
  localparam logic [31:0] B_CTS  = 32'h0008_0000;
  localparam logic [31:0] B_RLS  = 32'h0004_0000;
  localparam logic [31:0] B_LINI = 32'h0000_8080;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq, prdata_c2, rq_c2;
  logic        pready, pslverr, irq, re;
  logic        rx_nonempty, rx_activity, rx_active, rbr_read;
  logic        cts_change, buf_err_flag, timeout_flag;
  uis_rxerr_s  rx_err_ev;
  uis_lin_s    lin_status;
  int          mismatches, checks_done, cycles;

  uis_top #(.CHANNEL(0)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_nonempty(rx_nonempty),
    .rx_activity(rx_activity), .rx_active(rx_active),
    .rbr_read(rbr_read), .cts_change(cts_change), .rx_err_ev(rx_err_ev),
    .lin_status(lin_status), .buf_err_flag(buf_err_flag),
    .timeout_flag(timeout_flag), .irq(irq));

  // The third channel shares the stimulus and must never show a modem flag.
  uis_top #(.CHANNEL(2)) dut_ch2_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_c2),
    .pready(), .pslverr(), .rx_nonempty(rx_nonempty),
    .rx_activity(rx_activity), .rx_active(rx_active),
    .rbr_read(rbr_read), .cts_change(cts_change), .rx_err_ev(rx_err_ev),
    .lin_status(lin_status), .buf_err_flag(buf_err_flag),
    .timeout_flag(timeout_flag), .irq());

  uis_remote_model partner_u (
    .pclk(pclk), .cts_change(cts_change), .rx_err_ev(rx_err_ev),
    .lin_status(lin_status));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rq = prdata;
    rq_c2 = prdata_c2;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rq, exp);
  endtask

  task automatic t_reset();
    rd_chk("ier", `UIS_OFF_IER, 32'h0000_0000);
    rd_chk("tor", `UIS_OFF_TOR, 32'h0000_0040);
    wr(`UIS_OFF_ISR, 32'hFFFF_FFFF);
    rd_chk("isr", `UIS_OFF_ISR, 32'h0000_0000);
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk("pslverr", {31'h0000_0000, re}, 32'h0000_0001);
  endtask

  task automatic t_timeout();
    wr(`UIS_OFF_TOR, 32'h0000_0004);
    wr(`UIS_OFF_IER, 32'h0000_0010);
    wr(`UIS_OFF_IRQM, 32'h0000_003F);
    rx_nonempty <= 1'b1;
    rx_activity <= 1'b1;
    repeat (12) @(posedge pclk);
    rd_chk("isr busy", `UIS_OFF_ISR, 32'h0000_0000);
    rx_activity <= 1'b0;
    rd_chk("isr early", `UIS_OFF_ISR, 32'h0000_0000);
    repeat (10) @(posedge pclk);
    rd_chk("isr tout", `UIS_OFF_ISR, B_TOUT);
    chk("irq", {31'h0000_0000, irq}, 32'h0000_0001);
    rx_nonempty <= 1'b0;
    rx_active   <= 1'b1;
    rbr_read    <= 1'b1;
    @(posedge pclk);
    rbr_read    <= 1'b0;
    repeat (3) @(posedge pclk);
    rd_chk("isr clr", `UIS_OFF_ISR, 32'h0000_0000);
    wr(`UIS_OFF_IRQS, 32'h0000_003F);
    repeat (3) @(posedge pclk);
    chk("irq clr", {31'h0000_0000, irq}, 32'h0000_0000);
    wr(`UIS_OFF_IER, 32'h0000_0000);
  endtask

  task automatic t_cts();
    wr(`UIS_OFF_IER, 32'h0000_0008);
    partner_u.pulse_cts();
    repeat (4) @(posedge pclk);
    rd_chk("isr cts", `UIS_OFF_ISR, B_CTS);
    chk("isr ch2", rq_c2, 32'h0000_0000);
    rd_chk("irqs cts", `UIS_OFF_IRQS, 32'h0000_0010);
    chk("irqs ch2", rq_c2, 32'h0000_0000);
    wr(`UIS_OFF_MSR, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    rd_chk("isr cts clr", `UIS_OFF_ISR, 32'h0000_0000);
    wr(`UIS_OFF_IRQS, 32'h0000_003F);
    rd_chk("irqs cts clr", `UIS_OFF_IRQS, 32'h0000_0000);
    wr(`UIS_OFF_IER, 32'h0000_0000);
  endtask

  task automatic t_rls();
    logic [31:0] fsr;
    fsr = 32'h0000_0000;
    wr(`UIS_OFF_IER, 32'h0000_0004);
    for (int i = 0; i < 3; i++) begin
      partner_u.pulse_err(4'b1000 >> i);
      fsr = fsr | (32'h0000_0040 >> i);
      repeat (3) @(posedge pclk);
      rd_chk("isr rls", `UIS_OFF_ISR, B_RLS);
      rd_chk("fsr", `UIS_OFF_FSR, fsr);
    end
    rd_chk("irqs rls", `UIS_OFF_IRQS, 32'h0000_0008);
    for (int i = 0; i < 3; i++) begin
      wr(`UIS_OFF_FSR, 32'h0000_0040 >> i);
      repeat (3) @(posedge pclk);
      rd_chk("isr drop", `UIS_OFF_ISR, (i == 2) ? 32'h0 : B_RLS);
    end
    wr(`UIS_OFF_IRQS, 32'h0000_003F);
    rd_chk("irqs rls clr", `UIS_OFF_IRQS, 32'h0000_0000);
    partner_u.pulse_err(4'b0001);
    repeat (3) @(posedge pclk);
    rd_chk("isr plain addr", `UIS_OFF_ISR, 32'h0000_0000);
    wr(`UIS_OFF_MODE, 32'h0000_0001);
    partner_u.pulse_err(4'b1001);
    wr(`UIS_OFF_FSR, 32'h0000_0040);
    repeat (3) @(posedge pclk);
    rd_chk("isr addr", `UIS_OFF_ISR, B_RLS);
    wr(`UIS_OFF_FSR, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    rd_chk("isr addr clr", `UIS_OFF_ISR, 32'h0000_0000);
    wr(`UIS_OFF_MODE, 32'h0000_0000);
    wr(`UIS_OFF_IER, 32'h0000_0000);
  endtask

  task automatic t_lin();
    wr(`UIS_OFF_IER, 32'h0000_0100);
    for (int i = 0; i < 5; i++) begin
      partner_u.set_lin(5'b00001 << i);
      repeat (4) @(posedge pclk);
      rd_chk("isr lin", `UIS_OFF_ISR, B_LINI);
    end
    wr(`UIS_OFF_IER, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    rd_chk("isr lin off", `UIS_OFF_ISR, 32'h0000_0080);
    partner_u.set_lin(5'b00000);
    repeat (4) @(posedge pclk);
    rd_chk("isr lin clr", `UIS_OFF_ISR, 32'h0000_0000);
  endtask

  task automatic t_ind();
    logic [31:0] ex;
    for (int k = 0; k < 16; k++) begin
      wr(`UIS_OFF_IER, {26'h0, k[1:0], 4'h0});
      buf_err_flag <= k[3];
      timeout_flag <= k[2];
      repeat (3) @(posedge pclk);
      ex = {26'h0, k[3:2], 4'h0};
      ex = ex | ((ex & {26'h0, k[1:0], 4'h0}) << 8);
      wr(`UIS_OFF_ISR, 32'hFFFF_FFFF);
      rd_chk("isr ind", `UIS_OFF_ISR, ex);
    end
  endtask

  initial begin
    {psel, penable, pwrite, rx_nonempty, rx_activity} = '0;
    {rx_active, rbr_read, buf_err_flag, timeout_flag} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_timeout();
    t_cts();
    t_rls();
    t_lin();
    t_ind();
    end_of_test();
  end
endmodule

`default_nettype wire
